// [epds_regs.vh]
// Constants of the extended period divider scheduler.
// Assumes a 20 MHz SYS_CLK and a 12 MHz tick enable supplied from outside.
`ifndef EPDS_REGS_VH
`define EPDS_REGS_VH

// Handling step length in 12 MHz ticks
`define EPDS_STEP_TICKS      5'd18
// Reset and reload values
`define EPDS_MAIN_ZERO       16'h0000
`define EPDS_EXT_ZERO        24'h000000
`define EPDS_STEP_ZERO       5'h00
// Divider widths
`define EPDS_MAIN_W          16
`define EPDS_EXT_W           24
// Scheduler states
`define EPDS_ST_IDLE         2'd0
`define EPDS_ST_STEP         2'd1
`define EPDS_ST_WORK         2'd2

`endif

// [epds_sched_properties.sv]
// Port checker of the scheduler.
// Assumes TICK_12M pulses every other cycle.
`timescale 1ns/100ps
module epds_sched_properties (
    input wire SYS_CLK, SYS_RST, RUN, CLK_EN, HOST_STOP, WORK_LAUNCH, WORK_BUSY, STEP_BUSY, ACTIVE, MAIN_EXPIRY,
    input wire [15:0] MAIN_DIV,
    input wire [23:0] EXT_DIV, EXT_COUNT
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_step_run; STEP_BUSY ##33 STEP_BUSY; endsequence
    chk_step_len: assert property ($rose(STEP_BUSY) |-> s_step_run ##[1:4] !STEP_BUSY) else $error("step len");
    chk_expiry_step: assert property (MAIN_EXPIRY && !$past(STEP_BUSY) && !$past(WORK_BUSY) |-> STEP_BUSY)
        else $error("no step");
    chk_launch_work: assert property (WORK_LAUNCH |-> WORK_BUSY && EXT_COUNT == 0) else $error("launch");
    chk_idle_after: assert property ($fell(STEP_BUSY) && !WORK_LAUNCH |-> !WORK_BUSY) else $error("idle");
    chk_ext_range: assert property (ACTIVE |-> EXT_COUNT < EXT_DIV) else $error("ext range");
    chk_one_job: assert property (!(STEP_BUSY && WORK_BUSY)) else $error("overlap");
    chk_run_start: assert property (RUN && CLK_EN && !ACTIVE && MAIN_DIV != 0 && EXT_DIV != 0 |=> ACTIVE)
        else $error("start");
    chk_stop_seen: assert property ($fell(STEP_BUSY) && $past(HOST_STOP) |-> ##[0:1] !ACTIVE) else $error("stop");
endmodule // epds_sched_properties

// [epds_scheduler.v]
// Extended period divider scheduler: main divider, 24-bit extended
// counter, handling steps, single pending expiry and work launch.
// Assumes TICK_12M is a one-cycle pulse per 12 MHz tick, synchronous to SYS_CLK.
// Assumes MAIN_DIV and EXT_DIV stay stable while ACTIVE is high.
// Assumes the user work answers each launch with one WORK_DONE pulse.
//
// Behaviour
// - Trigger period equals main divider times extended divider ticks.
// - Main divider is a counter; extended divider a 24-bit expiry counter.
// - Each main expiry that is not dropped starts an 18-tick step advancing the extended count.
// - Without completion, go idle after the step until next expiry.
// - On completion, launch periodic work right after the step.
// - Each step samples a host stop request so it is noticed.
// - One expiry arriving during work is latched and handled afterwards.
// - A further expiry while one is pending is silently dropped.
// - Dropped periods are never recovered; extended count lags for good.
// - A delayed step done before next expiry leaves launch timing intact.
// - Work budget depends only on main divider value.
`timescale 1ns/100ps
`include "epds_regs.vh"

module epds_scheduler (
    // Clock, reset, enable
    input  wire        SYS_CLK,
    input  wire        SYS_RST,
    input  wire        CLK_EN,
    input  wire        TICK_12M,
    // Configuration and control
    input  wire [15:0] MAIN_DIV,
    input  wire [23:0] EXT_DIV,
    input  wire        RUN,
    input  wire        HOST_STOP,
    input  wire        WORK_DONE,
    // Status and events
    output reg         WORK_LAUNCH,
    output reg         WORK_BUSY,
    output reg         STEP_BUSY,
    output reg         ACTIVE,
    output reg         MAIN_EXPIRY,
    output reg  [23:0] EXT_COUNT
);

    // Counters and scheduler state
    reg [15:0] main_cnt;
    reg        pending;
    reg [1:0]  state;
    reg [4:0]  step_cnt;

    // Next values
    reg [15:0] next_main_cnt;
    reg [23:0] next_ext_count;
    reg        next_pending;
    reg [1:0]  next_state;
    reg [4:0]  next_step_cnt;
    reg        next_active;
    reg        next_work_launch;
    reg        next_work_busy;
    reg        next_step_busy;
    reg        next_main_expiry;

    // Decoded conditions
    wire       cfg_ok;
    wire       tick_on;
    wire       main_wrap;
    wire       main_hit;
    wire       step_last;
    wire       ext_done;
    wire       in_idle;
    wire       in_step;
    wire       in_work;
    wire       take_idle;
    wire       take_work;
    wire       take_any;
    wire       start_ok;
    wire       stop_now;
    wire       launch_now;

    // Last count before a 16-bit divider wraps
    function is_last16;
        input [15:0] cnt;
        input [15:0] div;
        begin
            is_last16 = (cnt == div - 16'h0001);
        end
    endfunction

    // Last count before the extended divider completes
    function is_last24;
        input [23:0] cnt;
        input [23:0] div;
        begin
            is_last24 = (cnt == div - 24'h000001);
        end
    endfunction

    // Last tick of a handling step
    function is_last5;
        input [4:0] cnt;
        input [4:0] len;
        begin
            is_last5 = (cnt == len - 5'h01);
        end
    endfunction

    // Both dividers must be nonzero before operation may start
    function cfg_valid;
        input [15:0] mdiv;
        input [23:0] ediv;
        begin
            cfg_valid = (mdiv != `EPDS_MAIN_ZERO) && (ediv != `EPDS_EXT_ZERO);
        end
    endfunction

    function [15:0] inc16;
        input [15:0] v;
        begin
            inc16 = v + 16'h0001;
        end
    endfunction

    function [23:0] inc24;
        input [23:0] v;
        begin
            inc24 = v + 24'h000001;
        end
    endfunction

    function [4:0] inc5;
        input [4:0] v;
        begin
            inc5 = v + 5'h01;
        end
    endfunction

    assign cfg_ok     = cfg_valid(MAIN_DIV, EXT_DIV);
    assign tick_on    = ACTIVE && TICK_12M;
    assign main_wrap  = is_last16(main_cnt, MAIN_DIV);
    assign main_hit   = tick_on && main_wrap;
    assign step_last  = in_step && TICK_12M && is_last5(step_cnt, `EPDS_STEP_TICKS);
    assign ext_done   = is_last24(EXT_COUNT, EXT_DIV);
    assign in_idle    = (state == `EPDS_ST_IDLE);
    assign in_step    = (state == `EPDS_ST_STEP);
    assign in_work    = (state == `EPDS_ST_WORK);
    // Pending expiry is consumed when idle, or when work finishes
    assign take_idle  = in_idle && ACTIVE && (pending || main_hit);
    assign take_work  = in_work && WORK_DONE && pending;
    assign take_any   = take_idle || take_work;
    assign start_ok   = !ACTIVE && RUN && cfg_ok;
    assign stop_now   = step_last && HOST_STOP;
    assign launch_now = step_last && !HOST_STOP && ext_done;

    // Hardware main divider, independent of the scheduler state
    always @* begin
        next_main_cnt = main_cnt;
        if (start_ok) begin
            next_main_cnt = `EPDS_MAIN_ZERO;
        end else if (tick_on) begin
            if (main_wrap)
                next_main_cnt = `EPDS_MAIN_ZERO;
            else
                next_main_cnt = inc16(main_cnt);
        end
    end

    // Single-entry pending latch; an expiry while one waits vanishes
    always @* begin
        next_pending = pending;
        if (take_any) begin
            // One expiry is consumed; a second at the same edge stays pending
            next_pending = main_hit && !(in_idle && !pending);
        end else if (main_hit && !in_idle) begin
            next_pending = 1'b1;
        end
        if (stop_now)
            next_pending = 1'b0;
    end

    // Scheduler: idle, handling step, periodic work
    always @* begin
        next_state    = state;
        next_step_cnt = step_cnt;
        case (state)
            `EPDS_ST_IDLE: begin
                if (take_idle) begin
                    next_state    = `EPDS_ST_STEP;
                    next_step_cnt = `EPDS_STEP_ZERO;
                end
            end
            `EPDS_ST_STEP: begin
                if (TICK_12M)
                    next_step_cnt = inc5(step_cnt);
                if (step_last) begin
                    if (stop_now)
                        next_state = `EPDS_ST_IDLE;
                    else if (ext_done)
                        next_state = `EPDS_ST_WORK;
                    else
                        next_state = `EPDS_ST_IDLE;
                end
            end
            `EPDS_ST_WORK: begin
                if (WORK_DONE) begin
                    if (take_work) begin
                        next_state    = `EPDS_ST_STEP;
                        next_step_cnt = `EPDS_STEP_ZERO;
                    end else begin
                        next_state = `EPDS_ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = `EPDS_ST_IDLE;
            end
        endcase
    end

    // Extended counter, advanced only at the end of a handling step
    always @* begin
        next_ext_count = EXT_COUNT;
        if (step_last) begin
            if (stop_now)
                next_ext_count = `EPDS_EXT_ZERO;
            else if (ext_done)
                next_ext_count = `EPDS_EXT_ZERO;
            else
                next_ext_count = inc24(EXT_COUNT);
        end
    end

    // Status and event outputs
    always @* begin
        next_active      = ACTIVE;
        next_work_launch = 1'b0;
        next_work_busy   = WORK_BUSY;
        next_step_busy   = STEP_BUSY;
        next_main_expiry = main_hit;
        if (start_ok)
            next_active = 1'b1;
        if (stop_now)
            next_active = 1'b0;
        if (take_any)
            next_step_busy = 1'b1;
        else if (step_last)
            next_step_busy = 1'b0;
        if (launch_now) begin
            next_work_launch = 1'b1;
            next_work_busy   = 1'b1;
        end
        if (in_work && WORK_DONE)
            next_work_busy = 1'b0;
    end

    // Divider and counter registers
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            main_cnt  <= `EPDS_MAIN_ZERO;
            EXT_COUNT <= `EPDS_EXT_ZERO;
            step_cnt  <= `EPDS_STEP_ZERO;
        end else if (CLK_EN) begin
            main_cnt  <= next_main_cnt;
            EXT_COUNT <= next_ext_count;
            step_cnt  <= next_step_cnt;
        end
    end

    // Scheduler registers
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state   <= `EPDS_ST_IDLE;
            pending <= 1'b0;
        end else if (CLK_EN) begin
            state   <= next_state;
            pending <= next_pending;
        end
    end

    // Output registers
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ACTIVE      <= 1'b0;
            WORK_LAUNCH <= 1'b0;
            WORK_BUSY   <= 1'b0;
            STEP_BUSY   <= 1'b0;
            MAIN_EXPIRY <= 1'b0;
        end else if (CLK_EN) begin
            ACTIVE      <= next_active;
            WORK_LAUNCH <= next_work_launch;
            WORK_BUSY   <= next_work_busy;
            STEP_BUSY   <= next_step_busy;
            MAIN_EXPIRY <= next_main_expiry;
        end
    end

endmodule // epds_scheduler

// [epds_user_work.sv]
// User periodic work model.
// Assumes launch is a one-cycle pulse on clk.
`timescale 1ns/100ps
module epds_user_work (
    input wire        clk,
    input wire        launch,
    input wire [15:0] dur,
    output reg        done
);
    reg [15:0] left = 16'h0000;
    initial done = 1'b0;
    always @(posedge clk) begin
        done <= left == 16'h0001;
        if (launch) left <= dur; else if (left != 16'h0000) left <= left - 16'h0001;
    end
endmodule // epds_user_work

// [tb_top.sv]
// Bench: period, late work, dropped expiry, stop.
// Assumes the work model and checker are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; $display("Error %s %0d %0d", n, e, a); end end
module tb_top;
    reg SYS_CLK = 0, SYS_RST = 1, TICK_12M = 0, RUN = 0, HOST_STOP = 0, CLK_EN = 1;
    reg [15:0] dur = 16'h0014;
    reg [15:0] MAIN_DIV = 16'h0028;
    reg [23:0] EXT_DIV = 24'h000000;
    wire WORK_DONE, WORK_LAUNCH, WORK_BUSY, STEP_BUSY, ACTIVE, MAIN_EXPIRY;
    wire [23:0] EXT_COUNT;
    int errors = 0, compares = 0, n;
    epds_scheduler dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .TICK_12M(TICK_12M),
        .MAIN_DIV(MAIN_DIV), .EXT_DIV(EXT_DIV), .RUN(RUN), .HOST_STOP(HOST_STOP), .WORK_DONE(WORK_DONE),
        .WORK_LAUNCH(WORK_LAUNCH), .WORK_BUSY(WORK_BUSY), .STEP_BUSY(STEP_BUSY), .ACTIVE(ACTIVE),
        .MAIN_EXPIRY(MAIN_EXPIRY), .EXT_COUNT(EXT_COUNT));
    epds_user_work work (.clk(SYS_CLK), .launch(WORK_LAUNCH), .dur(dur), .done(WORK_DONE));
    initial forever #25 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) TICK_12M <= ~TICK_12M;
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Cycles between two launches
    task automatic per(output int c);
        c = 0;
        @(posedge SYS_CLK iff WORK_LAUNCH);
        do begin @(posedge SYS_CLK); c++; end while (!WORK_LAUNCH);
    endtask
    // A zero EXT_DIV must not start; first expiry after MAIN_DIV ticks
    task automatic t_start;
        int c;
        c = 0;
        RUN <= 1;
        repeat (4) @(posedge SYS_CLK);
        `CHK("idle", 1'b0, ACTIVE)
        EXT_DIV <= 24'h000003;
        @(posedge SYS_CLK) RUN <= 0;
        do begin @(posedge SYS_CLK); c++; end while (!MAIN_EXPIRY);
        `CHK("first expiry", 2 * 40, c)
        `CHK("step", 1'b1, STEP_BUSY)
        `CHK("start count", 24'h000000, EXT_COUNT)
        $display("t_start");
    endtask
    task automatic t_norm; per(n); per(n); `CHK("period", 2 * 40 * 3, n) $display("t_norm"); endtask
    task automatic t_late; dur <= 60; per(n); per(n); `CHK("late", 2 * 40 * 3, n) $display("t_late"); endtask
    task automatic t_drop; dur <= 200; per(n); per(n); `CHK("lag", 2 * 40 * 4, n) $display("t_drop"); endtask
    // Low enable must hold the divider longer than one main period
    task automatic t_freeze;
        int seen;
        reg [23:0] v;
        seen = 0;
        v = EXT_COUNT;
        CLK_EN <= 0;
        repeat (100) begin @(posedge SYS_CLK); if (MAIN_EXPIRY) seen++; end
        CLK_EN <= 1;
        `CHK("frozen expiry", 0, seen)
        `CHK("frozen count", v, EXT_COUNT)
        `CHK("frozen active", 1'b1, ACTIVE)
        $display("t_freeze");
    endtask
    task automatic t_stop;
        HOST_STOP <= 1;
        for (int i = 0; i < 600 && ACTIVE; i++) @(posedge SYS_CLK);
        `CHK("active", 1'b0, ACTIVE)
        `CHK("count", 24'h000000, EXT_COUNT)
        $display("t_stop");
    endtask
    initial begin
        repeat (4) @(posedge SYS_CLK);
        SYS_RST <= 0;
        t_start; t_norm; t_late; t_drop; t_freeze; t_stop;
        end_sim;
    end
    initial begin #(12000 * 50); errors++; $display("Error watchdog 0 1"); end_sim; end
endmodule // tb_top
bind epds_scheduler epds_sched_properties chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .RUN(RUN), .CLK_EN(CLK_EN),
    .HOST_STOP(HOST_STOP), .WORK_LAUNCH(WORK_LAUNCH), .WORK_BUSY(WORK_BUSY), .STEP_BUSY(STEP_BUSY),
    .ACTIVE(ACTIVE), .MAIN_EXPIRY(MAIN_EXPIRY), .MAIN_DIV(MAIN_DIV), .EXT_DIV(EXT_DIV), .EXT_COUNT(EXT_COUNT));
